// ### sreg_pkg.sv
// Package with constants and carrier types for the serial register slave
package sreg_pkg;
  localparam int          IDX_W      = 7;      // Register index width
  localparam int          DATA_W     = 8;      // Register data width
  localparam int          NUM_REGS   = 128;    // Reachable register count
  localparam logic [6:0]  DEV_ADDR   = 7'h10;  // Seven-bit device address
  localparam logic [7:0]  ADDR_WR    = 8'h20;  // Address byte, write
  localparam logic [7:0]  ADDR_RD    = 8'h21;  // Address byte, read
  localparam int          DIR_BIT    = 0;      // Direction bit position
  localparam logic [6:0]  IDX_RST    = 7'h00;  // Index after reset
  localparam logic [3:0]  BIT_LAST   = 4'h7;   // Last bit count of a byte
  localparam int          SYNC_DEPTH = 2;      // Pin synchroniser stages
  localparam int          SCL_MAX_KHZ = 100;   // Fastest serial clock

  // Sampled bus line pair
  typedef struct packed {
    logic scl;
    logic sda;
  } line_pair_t;

  // Register bank access bundle
  typedef struct packed {
    logic [6:0] idx;
    logic       wr;
    logic [7:0] wdata;
  } bank_req_t;
endpackage : sreg_pkg

// ### line_sync.sv
// Two-stage synchroniser for the serial clock and data pins
`timescale 1ns/1ps
module line_sync #(
  parameter int STAGES = sreg_pkg::SYNC_DEPTH
) (
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  input  wire sreg_pkg::line_pair_t pins_i,
  output sreg_pkg::line_pair_t   sync_o
);
  // Stage registers; idle bus reads high
  sreg_pkg::line_pair_t stage_r [STAGES];

  // First stage feeds only the next stage
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_r[i] <= '1;
      end
    end else begin
      stage_r[0] <= pins_i;
      for (int i = 1; i < STAGES; i++) begin
        stage_r[i] <= stage_r[i-1];
      end
    end
  end

  assign sync_o = stage_r[STAGES-1];
endmodule : line_sync

// ### bus_events.sv
// Edge, start and stop detector on synchronised bus lines
`timescale 1ns/1ps
module bus_events (
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  input  wire sreg_pkg::line_pair_t line_i,
  output logic                   scl_rise_o,
  output logic                   scl_fall_o,
  output logic                   start_o,
  output logic                   stop_o,
  output logic                   sda_o
);
  sreg_pkg::line_pair_t prev_r;  // Previous sample of both lines

  // Keep last sample for edge finding
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prev_r <= '1;
    end else begin
      prev_r <= line_i;
    end
  end

  // Data edge with clock held high marks a condition
  assign scl_rise_o = line_i.scl & ~prev_r.scl;
  assign scl_fall_o = ~line_i.scl & prev_r.scl;
  assign start_o = line_i.scl & prev_r.scl & prev_r.sda & ~line_i.sda;
  assign stop_o  = line_i.scl & prev_r.scl & ~prev_r.sda & line_i.sda;
  assign sda_o   = line_i.sda;
endmodule : bus_events

// ### sreg_slave.sv
// Two-wire serial slave giving indexed access to a byte register bank
`timescale 1ns/1ps

// Limitation: no clock stretching, so each serial clock phase must
// outlast the four system clocks of synchroniser and edge finding
// plus a few clocks of margin for the data line to settle.
// Reset returns the index to zero; register contents live outside.

module sreg_slave #(
  parameter logic [6:0]   DEV_ADDR = sreg_pkg::DEV_ADDR,
  parameter logic [127:0] RO_MASK  = 128'h0
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe_o,
  output logic [6:0]                reg_idx_o,
  output logic                      reg_wr_o,
  output logic [7:0]                reg_wdata_o,
  input  wire logic [7:0]           reg_rdata_i,
  output logic                      busy_o
);
  // Slave states, one-hot
  // Codes written out so each state is a single flip-flop
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,  // Waiting for a start
    ST_ADDR = 7'h02,  // Receiving address byte
    ST_AACK = 7'h04,  // Address acknowledge slot
    ST_RX   = 7'h08,  // Receiving index or data
    ST_RACK = 7'h10,  // Receive acknowledge slot
    ST_TX   = 7'h20,  // Sending a byte
    ST_TACK = 7'h40   // Master acknowledge slot
  } state_t;

  // Internal nets and state
  sreg_pkg::line_pair_t pins;      // Raw pins
  sreg_pkg::line_pair_t lines;     // Synchronised pins
  logic       scl_rise;            // Serial clock rising
  logic       scl_fall;            // Serial clock falling
  logic       start_ev;            // Start or repeated start
  logic       stop_ev;             // Stop condition
  logic       sda_s;               // Synchronised data
  state_t     state_r;             // Current state
  logic [3:0] bit_cnt_r;           // Bits of current byte
  logic [7:0] shift_r;             // Serial/parallel register
  logic       dir_rd_r;            // Latched direction bit
  logic       have_idx_r;          // Index byte seen this message
  logic       first_tx_r;          // Next read byte is the index
  logic [6:0] idx_r;               // Register index pointer
  logic       ack_ok_r;            // Master acknowledged the byte
  logic       ack_nxt;             // Acknowledge decision

  // Pack the raw pins for the synchroniser
  assign pins.scl = scl_i;
  assign pins.sda = sda_i;

  // Pin synchroniser
  // Both lines pass the same stages so their order is kept
  line_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .pins_i    (pins),
    .sync_o    (lines)
  );

  // Bus condition detector
  // Conditions are judged only on synchronised samples
  bus_events u_events (
    .ref_clk_i  (ref_clk_i),
    .sys_rst_i  (sys_rst_i),
    .line_i     (lines),
    .scl_rise_o (scl_rise),
    .scl_fall_o (scl_fall),
    .start_o    (start_ev),
    .stop_o     (stop_ev),
    .sda_o      (sda_s)
  );

  // Seven-bit increment wraps naturally at the top
  // Used for writes and reads alike
  function automatic logic [6:0] idx_inc(input logic [6:0] v);
    idx_inc = 7'(v + 7'h01);
  endfunction : idx_inc

  // Address acknowledge decision on the full byte
  // Only the top seven bits name the device
  assign ack_nxt = (shift_r[7:1] == DEV_ADDR);

  // Protocol state machine; master is trusted on the clock rate
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= ST_IDLE;
    end else if (start_ev) begin
      state_r <= ST_ADDR;
    end else if (stop_ev) begin
      state_r <= ST_IDLE;
    end else if (scl_fall) begin
      unique case (state_r)
        ST_IDLE: begin
          // Bus traffic for others is ignored here
          state_r <= ST_IDLE;
        end
        ST_ADDR: begin
          // Judge the address once all eight bits are in
          if (bit_cnt_r == 4'h8) begin
            state_r <= ack_nxt ? ST_AACK : ST_IDLE;
          end
        end
        ST_AACK: begin
          // Direction taken from the address byte picks the path
          state_r <= dir_rd_r ? ST_TX : ST_RX;
        end
        ST_RX: begin
          // Index or data byte complete
          if (bit_cnt_r == 4'h8) begin
            state_r <= ST_RACK;
          end
        end
        ST_RACK: begin
          // Keep receiving until the master ends the message
          state_r <= ST_RX;
        end
        ST_TX: begin
          // Byte sent, master answers next
          if (bit_cnt_r == 4'h8) begin
            state_r <= ST_TACK;
          end
        end
        ST_TACK: begin
          // Negative acknowledge ends the read and frees the line
          state_r <= ack_ok_r ? ST_TX : ST_IDLE;
        end
        default: begin
          // Illegal one-hot code recovers to idle
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Bit counter: counts rising edges inside a byte
  // Count clears on the eighth fall; the slot's rising edge comes in an ack state, so it is not counted
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bit_cnt_r <= 4'h0;
    end else if (start_ev) begin
      bit_cnt_r <= 4'h0;
    end else if (scl_fall && (bit_cnt_r == 4'h8 ||
                 state_r == ST_AACK || state_r == ST_RACK ||
                 state_r == ST_TACK)) begin
      bit_cnt_r <= 4'h0;
    end else if (scl_rise && bit_cnt_r <= sreg_pkg::BIT_LAST &&
                 (state_r == ST_ADDR || state_r == ST_RX ||
                  state_r == ST_TX)) begin
      bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
    end
  end

  // Shift register: capture on rise, load and shift on fall
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_r <= 8'h00;
    end else if (scl_rise && (state_r == ST_ADDR || state_r == ST_RX)) begin
      shift_r <= {shift_r[6:0], sda_s};
    end else if (scl_fall && (state_r == ST_AACK ||
                 (state_r == ST_TACK && ack_ok_r))) begin
      // Index goes first, then register contents
      shift_r <= first_tx_r ? {1'b0, idx_r} : reg_rdata_i;
    end else if (scl_fall && state_r == ST_TX && bit_cnt_r != 4'h8) begin
      // Next bit moves to the top after each falling edge
      shift_r <= {shift_r[6:0], 1'b0};
    end
  end

  // Direction bit latch and message flags
  // A start resets the per-message flags; direction is relatched
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dir_rd_r   <= 1'b0;
      have_idx_r <= 1'b0;
      first_tx_r <= 1'b0;
    end else if (start_ev) begin
      have_idx_r <= 1'b0;
      first_tx_r <= 1'b1;
    end else if (scl_fall && state_r == ST_ADDR && bit_cnt_r == 4'h8) begin
      dir_rd_r <= shift_r[sreg_pkg::DIR_BIT];
    end else if (scl_fall && state_r == ST_RACK) begin
      have_idx_r <= 1'b1;
    end else if (scl_fall && state_r == ST_TX && bit_cnt_r == 4'h8) begin
      first_tx_r <= 1'b0;
    end
  end

  // Master acknowledge sampled on the ninth rising edge
  // Kept until the slot's falling edge decides the next step
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_ok_r <= 1'b0;
    end else if (scl_rise && state_r == ST_TACK) begin
      ack_ok_r <= ~sda_s;
    end
  end

  // Index pointer: set by write, advances per data byte, kept after stop
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idx_r <= sreg_pkg::IDX_RST;
    end else if (scl_fall && state_r == ST_RACK) begin
      if (!have_idx_r) begin
        // Index-only writes stop here, so no register changes
        idx_r <= shift_r[6:0];
      end else begin
        idx_r <= idx_inc(idx_r);
      end
    end else if (scl_fall && state_r == ST_TX && bit_cnt_r == 4'h8 &&
                 !first_tx_r) begin
      // The index byte itself does not advance the pointer
      idx_r <= idx_inc(idx_r);
    end
  end

  // Register bank write strobe after the acknowledge slot
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_wr_o    <= 1'b0;
      reg_wdata_o <= 8'h00;
    end else begin
      // Read-only locations never see a strobe
      // Data comes from the shifter, which holds still during the slot
      reg_wr_o <= scl_fall && state_r == ST_RACK && have_idx_r &&
                  !RO_MASK[idx_r];
      reg_wdata_o <= shift_r;
    end
  end

  // Index presented to the bank for reads and writes
  // Registered so the bank sees a steady index during a whole byte
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_idx_o <= sreg_pkg::IDX_RST;
    end else begin
      reg_idx_o <= idx_r;
    end
  end

  // Data line drive: ack low or transmit zero bits, else released
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sda_oe_o <= 1'b0;
    end else if (start_ev || stop_ev) begin
      sda_oe_o <= 1'b0;
    end else if (state_r == ST_AACK || state_r == ST_RACK) begin
      sda_oe_o <= 1'b1;
    end else if (state_r == ST_TX) begin
      // Last bit held through its high phase too; letting go while the
      // clock is high would look like a stop on the bus
      sda_oe_o <= ~shift_r[7];
    end else begin
      sda_oe_o <= 1'b0;
    end
  end

  // Open-drain output value is always low
  // Driving high is never allowed on a shared open-drain line
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // Message in progress flag
  // Follows the state one clock later, like every other output
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (state_r != ST_IDLE);
    end
  end
endmodule : sreg_slave

// ### sreg_slave_sva.sv
// Checker on the serial register slave top ports
`timescale 1ns/1ps
module sreg_slave_sva #(
  parameter logic [127:0] RO_MASK = 128'h0
) (
  input wire logic       ref_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic [6:0] reg_idx_o,
  input wire logic       reg_wr_o,
  input wire logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic       busy_o
);
  logic [6:0] idx_wr_r; // Index seen at the last write strobe
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Remember where the last strobe went, for the step check
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) idx_wr_r <= 7'h00;
    else if (reg_wr_o) idx_wr_r <= reg_idx_o;
  end
  drain_low_a: assert property (sda_o == 1'b0)
    else $error("data pin output value not low");
  wr_pulse_a: assert property (reg_wr_o |=> !reg_wr_o)
    else $error("write strobe longer than one cycle");
  wr_slot_a: assert property (reg_wr_o |-> busy_o && !scl_i)
    else $error("write strobe outside a message low phase");
  ro_keep_a: assert property (reg_wr_o |-> !RO_MASK[reg_idx_o])
    else $error("write strobe to a read-only register");
  // Index must step by one soon after each stored byte, wrapping at 127
  idx_step_a: assert property (reg_wr_o |=> ##[0:40]
    (reg_idx_o == idx_wr_r + 7'h01))
    else $error("index did not advance after a write");
  idx_hold_a: assert property (!busy_o && !$past(busy_o)
    |-> $stable(reg_idx_o))
    else $error("index changed between messages");
  // Drive changes only while the serial clock is low
  oe_scl_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed while clock high");
  oe_busy_a: assert property (sda_oe_o |-> busy_o)
    else $error("data line driven outside a message");
  rst_state_a: assert property ($fell(sys_rst_i) |->
    reg_idx_o == 7'h00 && !busy_o && !sda_oe_o && !reg_wr_o)
    else $error("outputs not idle after reset");
endmodule : sreg_slave_sva

// ### bus_master_model.sv
// Serial bus master model driving clock and data lines
`timescale 1ns/1ps
module bus_master_model (
  input  wire logic ref_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o,
  output logic [7:0] rx_byte_o,
  output logic      rx_vld_o
);
  // Phase length in ref clocks; design needs more than eight
  localparam int PH = 12;
  // Idle bus: both lines released high, clock stands still
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    rx_byte_o = 8'h00;
    rx_vld_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : wt
  // One bit: data set in low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    sda_o <= b;
    wt(PH);
    scl_o <= 1'b1;
    wt(PH / 2);
    s = sda_i;
    wt(PH / 2);
    scl_o <= 1'b0;
  endtask : bit_io
  // Data falls while clock high; also serves as repeated start
  task automatic start();
    sda_o <= 1'b1;
    wt(PH);
    scl_o <= 1'b1;
    wt(PH);
    sda_o <= 1'b0;
    wt(PH);
    scl_o <= 1'b0;
  endtask : start
  // Data rises while clock high
  task automatic stop();
    sda_o <= 1'b0;
    wt(PH);
    scl_o <= 1'b1;
    wt(PH);
    sda_o <= 1'b1;
    wt(PH);
  endtask : stop
  // Eight bits MSB first, then release for the ack
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask : send
  // Receive a byte, report it, then ack or nack
  task automatic recv(input logic ack);
    logic [7:0] v;
    logic       s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    rx_byte_o <= v;
    rx_vld_o <= 1'b1;
    wt(1);
    rx_vld_o <= 1'b0;
    bit_io(!ack, s);
  endtask : recv
endmodule : bus_master_model

// ### serial_register_access_slave_tb.sv
// Self-checking bench for the serial register slave
`timescale 1ns/1ps
module serial_register_access_slave_tb;
  localparam logic [127:0] RO = 128'h4; // Register 2 read-only
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        scl, sda_m, sda_out, sda_oe, wr, busy, rxv;
  logic [6:0]  idx, cur;
  logic [7:0]  wdata, rdata, rxb;
  logic [7:0]  lfsr_r = 8'h5A; // Random source state
  logic [7:0]  bank [128];     // Register bank beside the slave
  logic [7:0]  shadow [128];   // Expected bank contents
  logic [14:0] wq [$];         // Expected {index, data} writes
  logic [7:0]  rq [$];         // Expected read bytes
  int          err_count, cmp_count;
  // Pulled-up line; an enabled slave drives its output value onto it
  wire         sda_w = sda_oe ? (sda_m & sda_out) : sda_m;
  assign rdata = bank[idx];
  always #12.5 clk = ~clk;
  sreg_slave #(.RO_MASK(RO)) dut (.ref_clk_i(clk), .sys_rst_i(rst),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_out), .sda_oe_o(sda_oe),
    .reg_idx_o(idx), .reg_wr_o(wr), .reg_wdata_o(wdata),
    .reg_rdata_i(rdata), .busy_o(busy));
  bus_master_model mst (.ref_clk_i(clk), .sda_i(sda_w), .scl_o(scl),
    .sda_o(sda_m), .rx_byte_o(rxb), .rx_vld_o(rxv));
  function automatic logic [7:0] lfsr();
    lfsr_r = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
    return lfsr_r;
  endfunction : lfsr
  task automatic chk(input string n, input logic [14:0] e, s);
    cmp_count++;
    if (e !== s) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cmp_wr();
    logic [14:0] e;
    e = wq.size() ? wq.pop_front() : 'x;
    chk("write", e, {idx, wdata});
  endtask : cmp_wr
  task automatic cmp_rd();
    logic [7:0] e;
    e = rq.size() ? rq.pop_front() : 'x;
    chk("read", {7'h00, e}, {7'h00, rxb});
  endtask : cmp_rd
  task automatic cmp_ack(input logic e, g);
    chk("ack", {14'h0000, e}, {14'h0000, g});
  endtask : cmp_ack
  // Monitor: bank stores strobes, results checked against notes
  always @(posedge clk) begin
    if (wr === 1'b1) begin
      bank[idx] <= wdata;
      cmp_wr();
    end
    if (rxv === 1'b1) cmp_rd();
  end
  // Write message; fin low leaves the bus for a repeated start
  task automatic wr_msg(input logic [6:0] i, input int n, input logic fin);
    logic       a;
    logic [7:0] d;
    mst.start();
    mst.send(sreg_pkg::ADDR_WR, a);
    cmp_ack(1'b1, a);
    mst.send({1'b0, i}, a);
    cmp_ack(1'b1, a);
    cur = i;
    repeat (n) begin
      d = lfsr();
      mst.send(d, a);
      cmp_ack(1'b1, a);
      if (!RO[cur]) wq.push_back({cur, d});
      if (!RO[cur]) shadow[cur] = d;
      cur++;
    end
    if (fin) mst.stop();
  endtask : wr_msg
  // Read message: index first, then n registers, nack on the last
  task automatic rd_msg(input int n);
    logic a;
    mst.start();
    mst.send(sreg_pkg::ADDR_RD, a);
    cmp_ack(1'b1, a);
    rq.push_back({1'b0, cur});
    mst.recv(1'b1);
    for (int k = 0; k < n; k++) begin
      rq.push_back(shadow[cur]);
      cur++;
      mst.recv(k < n - 1);
    end
    mst.stop();
  endtask : rd_msg
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    logic a;
    for (int i = 0; i < 128; i++) bank[i] = 8'(i) ^ 8'hA5;
    for (int i = 0; i < 128; i++) shadow[i] = 8'(i) ^ 8'hA5;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk("index", 15'h0000, {8'h00, idx});
    wr_msg(7'h7E, 3, 1'b1);
    rd_msg(2);
    wr_msg(7'h01, 3, 1'b1);
    wr_msg(7'h7E, 0, 1'b0);
    rd_msg(3);
    wr_msg(7'h01, 0, 1'b0);
    rd_msg(3);
    // Foreign address: no ack, later bytes ignored
    mst.start();
    mst.send(8'h30, a);
    cmp_ack(1'b0, a);
    mst.send(8'h00, a);
    cmp_ack(1'b0, a);
    mst.send(lfsr(), a);
    cmp_ack(1'b0, a);
    mst.stop();
    rd_msg(1);
    repeat (50) @(posedge clk);
    chk("pending", 15'h0000, 15'(wq.size() + rq.size()));
    end_of_test();
  end
  // Watchdog well beyond the expected fifth of a millisecond
  initial begin
    #1ms;
    err_count++;
    end_of_test();
  end
endmodule : serial_register_access_slave_tb
bind sreg_slave sreg_slave_sva #(.RO_MASK(RO_MASK)) sva (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .reg_idx_o(reg_idx_o), .reg_wr_o(reg_wr_o), .reg_wdata_o(reg_wdata_o),
  .reg_rdata_i(reg_rdata_i), .busy_o(busy_o));
